// [rtl/adcof_pkg.sv]
// constants, field layouts and carrier types for the adc output path
// assumes one register slave on hclk and a sample path on its own clock
package adcof_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TRIM = 8'h04;
   localparam logic [7:0] OFS_PDM = 8'h08;
   localparam logic [7:0] OFS_LVDS = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   // ctrl fields
   localparam int B_TWOS = 0;
   localparam int B_LVDS = 1;
   localparam int B_LOWLAT = 2;
   localparam int B_PARCFG = 3;
   // trim fields
   localparam int B_EN = 0;
   localparam int B_FRZ = 1;
   localparam int B_TC = 4;
   // lvds fields
   localparam int B_CUR = 0;
   localparam int B_DBL = 2;
   localparam int B_TERM = 4;
   // stat fields
   localparam int B_MUX = 0;
   localparam int B_LLACT = 1;
   localparam int B_TWACT = 2;
   // ****************************************
   // codes
   // ****************************************
   localparam logic [1:0] CUR_3P5 = 2'h0; // 01 2.5, 10 4.5, 11 1.75 ma
   localparam logic [2:0] PD_NORM = 3'h0;
   localparam logic [2:0] PD_OFF_A = 3'h1;
   localparam logic [2:0] PD_OFF_B = 3'h2;
   localparam logic [2:0] PD_OFF_AB = 3'h3;
   localparam logic [2:0] PD_DOWN = 3'h4;
   localparam logic [2:0] PD_MUX = 3'h7;
   localparam logic [11:0] POS_OB = 12'h7FF;
   localparam logic [11:0] POS_TW = 12'h3FF;
   localparam logic [11:0] NEG_OB = 12'h000;
   localparam logic [11:0] NEG_TW = 12'h400;
   localparam logic [11:0] CODE_MSB = 12'h800;
   localparam logic [11:0] CODE_MAX = 12'hFFF;
   localparam logic signed [13:0] MID14 = 14'sh0800;
   localparam logic signed [13:0] MAX14 = 14'sh0FFF;
   localparam int LAT_NORM = 14;
   localparam int LAT_LOW = 10;
   // loop time constant exponents
   localparam logic [5:0] TC_E0 = 6'h1B;
   localparam logic [5:0] TC_E1 = 6'h1A;
   localparam logic [5:0] TC_E2 = 6'h19;
   localparam logic [5:0] TC_E3 = 6'h18;
   localparam logic [5:0] TC_E4 = 6'h1C;
   localparam logic [5:0] TC_E5 = 6'h1D;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic ovp;
      logic ovn;
      logic [11:0] code;
   } adcof_smp_t;
   typedef struct packed {
      logic twos;
      logic lvds;
      logic low_lat;
      logic par_cfg;
      logic trim_en;
      logic freeze;
      logic [2:0] tc;
      logic [2:0] pd;
   } adcof_cfg_t;
   localparam adcof_cfg_t CFG_RST = '0;
endpackage

// [rtl/adcof_top.sv]
// adc output formatting, mux mode, latency select and dc offset trim loop
// assumes an ahb-lite master on hclk and sample producer on smp_clk
module adcof_top #(
   parameter int ACC_W = 43
) (
   // ahb-lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // sample side
   input wire logic smp_clk,
   input wire adcof_pkg::adcof_smp_t smp_a,
   input wire adcof_pkg::adcof_smp_t smp_b,
   // configuration pins
   input wire logic config_select_pin,
   input wire logic mode_pin_one,
   input wire logic mode_pin_two,
   input wire logic mode_pin_three,
   // output buses, three-state as out plus enable
   output logic [11:0] chan_a_bus,
   output logic chan_a_oe,
   output logic [11:0] chan_b_bus,
   output logic chan_b_oe,
   output logic mux_phase,
   // lvds buffer settings
   output logic [1:0] lvds_cur_sel,
   output logic data_cur_dbl,
   output logic clk_cur_dbl,
   output logic [2:0] lvds_term_en
);
   // ****************************************
   // register slave on hclk
   // ****************************************
   adcof_pkg::adcof_cfg_t cfg_q, hold_q, cfg_s_q;
   logic [1:0] cur_q;
   logic dbl_q;
   logic [2:0] term_q;
   logic a_val_q, a_wr_q;
   logic [7:0] a_ofs_q;
   logic [31:0] rd_q, rd_c;
   logic [2:0] st_m_q, st_s_q, st_c;
   logic acc_en;

   assign hreadyout = 1'b1; // zero wait states, every access done in one data phase
   assign hresp = 1'b0;
   assign hrdata = rd_q;
   assign lvds_cur_sel = cur_q;
   assign data_cur_dbl = dbl_q;
   assign clk_cur_dbl = dbl_q;
   assign lvds_term_en = term_q;
   assign acc_en = hsel && htrans[1] && hready;
   // address phase capture; sizes other than a word are treated as a word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_val_q <= 1'b0;
         a_wr_q <= 1'b0;
         a_ofs_q <= 8'h00;
      end else if (hready) begin
         a_val_q <= acc_en;
         a_wr_q <= hwrite;
         a_ofs_q <= {haddr[7:2], 2'b00};
      end
   end
   // read mux, unmapped reads as zero
   always_comb begin
      rd_c = 32'h0000_0000;
      unique case ({haddr[7:2], 2'b00})
         adcof_pkg::OFS_CTRL: begin
            rd_c[adcof_pkg::B_TWOS] = cfg_q.twos;
            rd_c[adcof_pkg::B_LVDS] = cfg_q.lvds;
            rd_c[adcof_pkg::B_LOWLAT] = cfg_q.low_lat;
            rd_c[adcof_pkg::B_PARCFG] = cfg_q.par_cfg;
         end
         adcof_pkg::OFS_TRIM: begin
            rd_c[adcof_pkg::B_EN] = cfg_q.trim_en;
            rd_c[adcof_pkg::B_FRZ] = cfg_q.freeze;
            rd_c[adcof_pkg::B_TC +: 3] = cfg_q.tc;
         end
         adcof_pkg::OFS_PDM: rd_c[2:0] = cfg_q.pd;
         adcof_pkg::OFS_LVDS: begin
            rd_c[adcof_pkg::B_CUR +: 2] = cur_q;
            rd_c[adcof_pkg::B_DBL] = dbl_q;
            rd_c[adcof_pkg::B_TERM +: 3] = term_q;
         end
         adcof_pkg::OFS_STAT: rd_c[2:0] = st_s_q;
         default: rd_c = 32'h0000_0000;
      endcase
   end
   // read data registered at the address phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 32'h0000_0000;
      end else if (acc_en && !hwrite) begin
         rd_q <= rd_c;
      end
   end
   // register writes in the data phase; reset leaves trim off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= adcof_pkg::CFG_RST;
         cur_q <= adcof_pkg::CUR_3P5;
         dbl_q <= 1'b0;
         term_q <= 3'h0;
      end else if (a_val_q && a_wr_q) begin
         unique case (a_ofs_q)
            adcof_pkg::OFS_CTRL: begin
               cfg_q.twos <= hwdata[adcof_pkg::B_TWOS];
               cfg_q.lvds <= hwdata[adcof_pkg::B_LVDS];
               cfg_q.low_lat <= hwdata[adcof_pkg::B_LOWLAT];
               cfg_q.par_cfg <= hwdata[adcof_pkg::B_PARCFG];
            end
            adcof_pkg::OFS_TRIM: begin
               cfg_q.trim_en <= hwdata[adcof_pkg::B_EN];
               cfg_q.freeze <= hwdata[adcof_pkg::B_FRZ];
               cfg_q.tc <= hwdata[adcof_pkg::B_TC +: 3];
            end
            adcof_pkg::OFS_PDM: cfg_q.pd <= hwdata[2:0];
            adcof_pkg::OFS_LVDS: begin
               cur_q <= hwdata[adcof_pkg::B_CUR +: 2];
               dbl_q <= hwdata[adcof_pkg::B_DBL];
               term_q <= hwdata[adcof_pkg::B_TERM +: 3];
            end
            default: ;
         endcase
      end
   end

   // ****************************************
   // config crossing, toggle handshake
   // ****************************************
   logic req_q, ack_m_q, ack_s_q;
   logic req_m_q, req_s_q, ack_q;
   // hold word is launched only when the previous one was taken, so it never moves while read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q <= adcof_pkg::CFG_RST;
         req_q <= 1'b0;
         ack_m_q <= 1'b0;
         ack_s_q <= 1'b0;
      end else begin
         ack_m_q <= ack_q;
         ack_s_q <= ack_m_q;
         if (req_q == ack_s_q && hold_q != cfg_q) begin
            hold_q <= cfg_q;
            req_q <= ~req_q;
         end
      end
   end
   // status bits back into hclk, each an independent level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_m_q <= 3'h0;
         st_s_q <= 3'h0;
      end else begin
         st_m_q <= st_c;
         st_s_q <= st_m_q;
      end
   end

   // ****************************************
   // sample clock domain
   // ****************************************
   logic rs1_q, srst_n;
   logic [3:0] pin_m_q, pin_s_q;
   logic mux_c, twos_c, lowlat_c;
   logic [2:0] pd_c;
   // reset asserts at once and releases on smp_clk
   always_ff @(posedge smp_clk or negedge hresetn) begin
      if (!hresetn) begin
         rs1_q <= 1'b0;
         srst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         srst_n <= rs1_q;
      end
   end

   // take the config word once its toggle has settled
   always_ff @(posedge smp_clk or negedge srst_n) begin
      if (!srst_n) begin
         req_m_q <= 1'b0;
         req_s_q <= 1'b0;
         ack_q <= 1'b0;
         cfg_s_q <= adcof_pkg::CFG_RST;
      end else begin
         req_m_q <= req_q;
         req_s_q <= req_m_q;
         if (req_s_q != ack_q) begin
            cfg_s_q <= hold_q;
            ack_q <= req_s_q;
         end
      end
   end

   // pins are asynchronous to smp_clk
   always_ff @(posedge smp_clk or negedge srst_n) begin
      if (!srst_n) begin
         pin_m_q <= 4'h0;
         pin_s_q <= 4'h0;
      end else begin
         pin_m_q <= {config_select_pin, mode_pin_one, mode_pin_two, mode_pin_three};
         pin_s_q <= pin_m_q;
      end
   end

   // effective mode: pins rule format and power mode in parallel configuration
   assign twos_c = cfg_s_q.par_cfg ? pin_s_q[3] : cfg_s_q.twos;
   assign pd_c = cfg_s_q.par_cfg ? pin_s_q[2:0] : cfg_s_q.pd;
   assign mux_c = (pd_c == adcof_pkg::PD_MUX) && !cfg_s_q.lvds;
   assign lowlat_c = cfg_s_q.low_lat;
   assign st_c = {twos_c, lowlat_c, mux_c};

   // ****************************************
   // delay line and offset loop per channel
   // ****************************************
   adcof_pkg::adcof_smp_t smp_in [2];
   adcof_pkg::adcof_smp_t dl_q [2][adcof_pkg::LAT_NORM];
   adcof_pkg::adcof_smp_t tap_c [2];
   logic signed [ACC_W-1:0] acc_q [2];
   logic [11:0] code_c [2];
   logic [11:0] fmt_c [2];
   logic [5:0] sh_c;

   assign smp_in[0] = smp_a;
   assign smp_in[1] = smp_b;

   // time constant select, spare codes fall back to 2^27
   always_comb begin
      unique case (cfg_s_q.tc)
         3'h1: sh_c = adcof_pkg::TC_E1;
         3'h2: sh_c = adcof_pkg::TC_E2;
         3'h3: sh_c = adcof_pkg::TC_E3;
         3'h4: sh_c = adcof_pkg::TC_E4;
         3'h5: sh_c = adcof_pkg::TC_E5;
         default: sh_c = adcof_pkg::TC_E0;
      endcase
   end

   function automatic logic [11:0] clamp_f(input logic signed [13:0] v);
      if (v < 0) return 12'h000;
      if (v > adcof_pkg::MAX14) return adcof_pkg::CODE_MAX;
      return v[11:0];
   endfunction

   function automatic logic [11:0] fmt_f(input adcof_pkg::adcof_smp_t s, input logic [11:0] c, input logic tw);
      if (s.ovp) return tw ? adcof_pkg::POS_TW : adcof_pkg::POS_OB;
      if (s.ovn) return tw ? adcof_pkg::NEG_TW : adcof_pkg::NEG_OB;
      return tw ? (c ^ adcof_pkg::CODE_MSB) : c;
   endfunction

   for (genvar g = 0; g < 2; g++) begin : g_ch
      logic signed [12:0] corr;
      logic signed [13:0] err, fix;
      // estimate is the loop integral scaled by the time constant
      assign corr = 13'(acc_q[g] >>> sh_c);
      assign err = $signed({2'b00, smp_in[g].code}) - adcof_pkg::MID14 - {corr[12], corr};
      assign fix = $signed({2'b00, tap_c[g].code}) - {corr[12], corr};

      // integrate only while enabled and not frozen; disabled keeps state for resume
      always_ff @(posedge smp_clk or negedge srst_n) begin
         if (!srst_n) begin
            acc_q[g] <= '0;
         end else if (cfg_s_q.trim_en && !cfg_s_q.freeze) begin
            acc_q[g] <= acc_q[g] + ACC_W'(err);
         end
      end

      // fixed pipeline; the tap sets the latency
      always_ff @(posedge smp_clk or negedge srst_n) begin
         if (!srst_n) begin
            for (int i = 0; i < adcof_pkg::LAT_NORM; i++) dl_q[g][i] <= '0;
         end else begin
            dl_q[g][0] <= smp_in[g];
            for (int i = 1; i < adcof_pkg::LAT_NORM; i++) dl_q[g][i] <= dl_q[g][i-1];
         end
      end

      assign tap_c[g] = lowlat_c ? dl_q[g][adcof_pkg::LAT_LOW-1] : dl_q[g][adcof_pkg::LAT_NORM-1];
      // low latency skips the trim correction; the loop still integrates
      assign code_c[g] = (cfg_s_q.trim_en && !lowlat_c) ? clamp_f(fix) : tap_c[g].code;
      assign fmt_c[g] = fmt_f(tap_c[g], code_c[g], twos_c);
   end

   // ****************************************
   // output buses
   // ****************************************
   // mux mode interleaves one sample per clock, a then b; the b bus thus carries half of each channel
   always_ff @(posedge smp_clk or negedge srst_n) begin
      if (!srst_n) begin
         chan_a_bus <= 12'h000;
         chan_b_bus <= 12'h000;
         chan_a_oe <= 1'b0;
         chan_b_oe <= 1'b0;
         mux_phase <= 1'b0;
      end else begin
         chan_a_bus <= fmt_c[0];
         mux_phase <= mux_c ? ~mux_phase : 1'b0;
         chan_b_bus <= (mux_c && !mux_phase) ? fmt_c[0] : fmt_c[1];
         chan_a_oe <= !(mux_c || pd_c == adcof_pkg::PD_OFF_A || pd_c == adcof_pkg::PD_OFF_AB ||
                        pd_c == adcof_pkg::PD_DOWN);
         chan_b_oe <= !(pd_c == adcof_pkg::PD_OFF_B || pd_c == adcof_pkg::PD_OFF_AB ||
                        pd_c == adcof_pkg::PD_DOWN);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_clean_b;
      !smp_b.ovp && !smp_b.ovn;
   endsequence
   sequence s_plain_out;
      !mux_c && !twos_c && !cfg_s_q.trim_en && $stable(cfg_s_q);
   endsequence
   lat_normal_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      s_clean_b ##14 (s_plain_out and (!lowlat_c && $past(cfg_s_q, 13) == cfg_s_q)) |=>
      chan_b_bus == $past(smp_b.code, 15)) else $error("normal latency wrong");
   lat_low_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      s_clean_b ##10 (lowlat_c && !mux_c && !twos_c && $past(cfg_s_q, 9) == cfg_s_q) |=>
      chan_b_bus == $past(smp_b.code, 11)) else $error("low latency path wrong");
   pos_ovr_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      (tap_c[1].ovp && !mux_c) |=> chan_b_bus == ($past(twos_c) ? adcof_pkg::POS_TW : adcof_pkg::POS_OB))
      else $error("positive overdrive code wrong");
   neg_ovr_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      (tap_c[0].ovn && !tap_c[0].ovp) |=> chan_a_bus == ($past(twos_c) ? adcof_pkg::NEG_TW : adcof_pkg::NEG_OB))
      else $error("negative overdrive code wrong");
   mux_release_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      mux_c [*2] |-> !chan_a_oe && (mux_phase != $past(mux_phase))) else $error("mux mode bus a driven");
   mux_cmos_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      cfg_s_q.lvds |=> !mux_phase) else $error("mux active with lvds");
   trim_hold_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      (cfg_s_q.freeze || !cfg_s_q.trim_en) |=> $stable(acc_q[0]) && $stable(acc_q[1]))
      else $error("offset estimate moved while held");
   trim_pass_a: assert property (@(posedge smp_clk) disable iff (!srst_n)
      (!cfg_s_q.trim_en && !tap_c[0].ovp && !tap_c[0].ovn && !twos_c) |=> chan_a_bus == $past(tap_c[0].code))
      else $error("sample altered with trim off");
   trim_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !(a_val_q && a_wr_q) && !cfg_q.trim_en |=> !cfg_q.trim_en) else $error("trim enabled without write");
endmodule

// [verif/adcof_rx_model.sv]
// receiver model standing at the far end of the two output buses
// assumes the device launches words on smp_clk and drives each bus only while its enable is high
module adcof_rx_model (
   // sample clock
   input wire logic smp_clk,
   // device output buses
   input wire logic [11:0] chan_a_bus,
   input wire logic chan_a_oe,
   input wire logic [11:0] chan_b_bus,
   input wire logic chan_b_oe,
   // pin levels as the receiver sees them
   output logic [11:0] wire_a,
   output logic [11:0] wire_b
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [11:0] last_a_q;
   logic [11:0] last_b_q;
   // ****************************************
   // bus resolution
   // ****************************************
   // keep the last driven word so that a released bus cannot pass for a live one
   always @(posedge smp_clk) begin
      if (chan_a_oe) begin
         last_a_q <= chan_a_bus;
      end
      if (chan_b_oe) begin
         last_b_q <= chan_b_bus;
      end
   end
   // no pull on these pins: a floating bus shows the inverse of its last word
   assign wire_a = chan_a_oe ? chan_a_bus : ~last_a_q;
   assign wire_b = chan_b_oe ? chan_b_bus : ~last_b_q;
endmodule

// [verif/adc_output_format_offset_loop_tb.sv]
// self-checking bench for the adc output path: registers, format, mux, latency and trim loop
// assumes the package, the design top and the receiver model are compiled before it
module adc_output_format_offset_loop_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, smp_clk, cfg_pin, m1, m2, m3;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   adcof_pkg::adcof_smp_t smp_a, smp_b;
   logic [11:0] chan_a_bus, chan_b_bus, wire_a, wire_b;
   logic chan_a_oe, chan_b_oe, mux_phase, data_cur_dbl, clk_cur_dbl;
   logic [1:0] lvds_cur_sel;
   logic [2:0] lvds_term_en;
   int bad_count, comparisons;
   real smp_half = 7.5;
   // ****************************************
   // clocks, instances
   // ****************************************
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // link clock at 15 ns, slowed while muxed; offset so its edges never line up with hclk
   initial begin
      smp_clk = 1'b0;
      #1.3;
      forever #(smp_half) smp_clk = ~smp_clk;
   end
   adcof_top adcof_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .smp_clk(smp_clk), .smp_a(smp_a), .smp_b(smp_b), .config_select_pin(cfg_pin),
      .mode_pin_one(m1), .mode_pin_two(m2), .mode_pin_three(m3), .chan_a_bus(chan_a_bus), .chan_a_oe(chan_a_oe),
      .chan_b_bus(chan_b_bus), .chan_b_oe(chan_b_oe), .mux_phase(mux_phase), .lvds_cur_sel(lvds_cur_sel),
      .data_cur_dbl(data_cur_dbl), .clk_cur_dbl(clk_cur_dbl), .lvds_term_en(lvds_term_en));
   adcof_rx_model adcof_rx_model_inst (.smp_clk(smp_clk), .chan_a_bus(chan_a_bus), .chan_a_oe(chan_a_oe),
      .chan_b_bus(chan_b_bus), .chan_b_oe(chan_b_oe), .wire_a(wire_a), .wire_b(wire_b));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic adcof_pkg::adcof_smp_t mk(input logic p, input logic n, input logic [11:0] c);
      mk = {p, n, c};
   endfunction
   // one single ahb transfer; the master never assumes a wait count, it polls hready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      hsel <= 1'b0;
   endtask
   // land just after the edge so outputs launched on it have settled
   task automatic wait_smp(input int n);
      repeat (n) @(posedge smp_clk);
      #1;
   endtask
   // change the inputs once, then check bus b does not yet show the new word one edge short and the new one lands on time
   task automatic lat_chk(input adcof_pkg::adcof_smp_t sa, input adcof_pkg::adcof_smp_t sb, input int lat,
      input logic [11:0] ea, input logic [11:0] eb);
      @(posedge smp_clk);
      smp_a <= sa;
      smp_b <= sb;
      repeat (lat) @(posedge smp_clk);
      #1;
      chk("bus_b_early", 32'h1, {31'h0, chan_b_bus !== eb});
      @(posedge smp_clk);
      #1;
      chk("bus_a", {20'h0, ea}, {20'h0, chan_a_bus});
      chk("bus_b", {20'h0, eb}, {20'h0, chan_b_bus});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
      xfer(1'b1, 8'h20, 32'hFFFFFFFF, rd);
      foreach (ofs[i]) begin
         xfer(1'b0, ofs[i], 32'h0, rd);
         chk("reg_reset", 32'h0, rd);
      end
      chk("cur_sel", {30'h0, adcof_pkg::CUR_3P5}, {30'h0, lvds_cur_sel});
      chk("oe_pair", 32'h3, {30'h0, chan_a_oe, chan_b_oe});
      $display("test reset done");
   endtask
   task automatic t_lvds;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, adcof_pkg::OFS_LVDS, {25'h0, i[2:0], 1'b0, i[2], i[1:0]}, rd);
         repeat (2) @(posedge hclk);
         chk("cur_sel", {30'h0, i[1:0]}, {30'h0, lvds_cur_sel});
         chk("dbl", {30'h0, i[2], i[2]}, {30'h0, data_cur_dbl, clk_cur_dbl});
         chk("term", {29'h0, i[2:0]}, {29'h0, lvds_term_en});
      end
      $display("test lvds done");
   endtask
   task automatic t_format;
      for (int tw = 0; tw < 2; tw++) begin
         xfer(1'b1, adcof_pkg::OFS_CTRL, {31'h0, tw[0]}, rd);
         wait_smp(12);
         lat_chk(mk(0, 0, 12'h123), mk(0, 0, 12'h456), 14, tw ? 12'h923 : 12'h123, tw ? 12'hC56 : 12'h456);
         lat_chk(mk(1, 0, 12'h555), mk(1, 0, 12'h555), 14, tw ? 12'h3FF : 12'h7FF, tw ? 12'h3FF : 12'h7FF);
         lat_chk(mk(0, 1, 12'h555), mk(0, 1, 12'h555), 14, tw ? 12'h400 : 12'h000, tw ? 12'h400 : 12'h000);
      end
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h4, rd);
      wait_smp(12);
      lat_chk(mk(0, 0, 12'h321), mk(0, 0, 12'h654), 10, 12'h321, 12'h654);
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h0, rd);
      $display("test format done");
   endtask
   task automatic t_mux;
      logic ph;
      for (int p = 0; p < 5; p++) begin
         xfer(1'b1, adcof_pkg::OFS_PDM, p, rd);
         wait_smp(12);
         chk("a_oe", {31'h0, !(p inside {1, 3, 4})}, {31'h0, chan_a_oe});
         chk("b_oe", {31'h0, !(p inside {2, 3, 4})}, {31'h0, chan_b_oe});
      end
      smp_half = 8.0; // shared bus runs at the clock rate, so keep the sample rate under 65 msps
      @(posedge smp_clk);
      smp_a <= mk(0, 0, 12'h111);
      smp_b <= mk(0, 0, 12'h222);
      xfer(1'b1, adcof_pkg::OFS_PDM, 32'h7, rd);
      wait_smp(20);
      chk("a_oe_mux", 32'h0, {31'h0, chan_a_oe});
      ph = mux_phase;
      for (int i = 0; i < 4; i++) begin
         @(posedge smp_clk);
         #1;
         chk("mux_phase", {31'h0, ~ph}, {31'h0, mux_phase});
         chk("mux_word", mux_phase ? 32'h111 : 32'h222, {20'h0, wire_b});
         ph = mux_phase;
      end
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h2, rd);
      wait_smp(12);
      chk("a_oe_lvds", 32'h1, {31'h0, chan_a_oe});
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h8, rd);
      xfer(1'b1, adcof_pkg::OFS_PDM, 32'h0, rd);
      @(posedge smp_clk);
      {m1, m2, m3} <= 3'h7;
      wait_smp(12);
      chk("a_oe_pins", 32'h0, {31'h0, chan_a_oe});
      @(posedge smp_clk);
      {m1, m2, m3} <= 3'h0;
      cfg_pin <= 1'b1;
      smp_half = 7.5;
      wait_smp(12);
      lat_chk(mk(0, 0, 12'h123), mk(0, 0, 12'h456), 14, 12'h923, 12'hC56);
      cfg_pin <= 1'b0;
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h0, rd);
      $display("test mux done");
   endtask
   // trim with the shortest loop constant: input 0xFA0 moves the correction by one code per 2^24 of error
   task automatic t_trim;
      int n;
      @(posedge smp_clk);
      smp_a <= mk(0, 0, 12'hFA0);
      smp_b <= mk(0, 0, 12'hFA0);
      wait_smp(20);
      xfer(1'b1, adcof_pkg::OFS_TRIM, 32'h31, rd);
      for (n = 0; n < 10000 && chan_b_bus === 12'hFA0; n++) @(posedge smp_clk);
      #1;
      chk("trim_b", 32'hF9F, {20'h0, chan_b_bus});
      chk("trim_a", 32'hF9F, {20'h0, chan_a_bus});
      xfer(1'b1, adcof_pkg::OFS_TRIM, 32'h33, rd);
      wait_smp(9000);
      chk("frozen", 32'hF9F, {20'h0, chan_b_bus});
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h4, rd);
      wait_smp(20);
      chk("low_lat_raw", 32'hFA0, {20'h0, chan_b_bus});
      xfer(1'b1, adcof_pkg::OFS_CTRL, 32'h0, rd);
      xfer(1'b1, adcof_pkg::OFS_TRIM, 32'h0, rd);
      wait_smp(20);
      chk("trim_off", 32'hFA0, {20'h0, chan_b_bus});
      xfer(1'b1, adcof_pkg::OFS_TRIM, 32'h31, rd);
      wait_smp(20);
      chk("trim_resume", 32'hF9F, {20'h0, chan_b_bus});
      $display("test trim done");
   endtask
   // ****************************************
   // run control
   // ****************************************
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // the trim scenario dominates at about 18k link cycles, so this leaves ample margin
   initial begin
      #400us;
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      results();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      smp_a = '0;
      smp_b = '0;
      cfg_pin = 1'b0;
      {m1, m2, m3} = 3'h0;
      bad_count = 0;
      comparisons = 0;
      // the link side resets at once and releases through its own synchroniser
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_reset();
      t_lvds();
      t_format();
      t_mux();
      t_trim();
      results();
   end
endmodule
